// *** src/pic_pkg.sv ***
package pic_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_SRC  = 16;
  localparam int SRC_W    = 4;
  localparam int NUM_PIN  = 8;
  localparam int NUM_PER  = 4;
  localparam int LVL_W    = 2;
  localparam int DATA_W   = 32;
  localparam int APB_AW   = 14;
  localparam int IDX_W    = 12;
  localparam int REG_W    = 8;
  localparam int ST_W     = 2;

  typedef logic [LVL_W-1:0] pic_level_t;

  localparam pic_level_t LVL_OFF = 2'h0;
  localparam pic_level_t LVL_1   = 2'h1;
  localparam pic_level_t LVL_3   = 2'h3;

  // ---------------------------------------------------------------
  // source map
  // ---------------------------------------------------------------
  localparam int PIN_BASE    = 0;
  localparam int PER_BASE    = 8;
  localparam int SRC_WDT     = 12;
  localparam int SRC_PRI_OSC = 13;
  localparam int SRC_WDT_OSC = 14;
  localparam int SRC_ILLEGAL = 15;
  localparam int PIN_SHARED  = 6;

  localparam logic [NUM_SRC-1:0] FORCED_ALWAYS = 16'he000;
  localparam logic [NUM_SRC-1:0] FORCED_IF_EN  = 16'h1000;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PENDING  = 12'hfc0;
  localparam logic [IDX_W-1:0] IDX_LEVEL    = 12'hfc1;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 12'hfc2;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 12'hfc3;
  localparam logic [IDX_W-1:0] IDX_MASK     = 12'hfc4;
  localparam logic [IDX_W-1:0] IDX_EDGE_POL = 12'hfcd;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL  = 12'hfce;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_GIE_BIT  = 0;
  localparam int SEL_PIN6_BIT  = 6;
  localparam int ST_ACK_BIT    = 0;
  localparam int ST_TRAP_BIT   = 1;

  localparam logic [REG_W-1:0]       RST_EDGE_POL = 8'h00;
  localparam logic [REG_W-1:0]       RST_SRC_SEL  = 8'h00;
  localparam logic [NUM_SRC-1:0]     RST_PENDING  = 16'h0000;
  localparam logic [2*NUM_SRC-1:0]   RST_LEVEL    = 32'h0000_0000;
  localparam logic [ST_W-1:0]        RST_ST       = 2'h0;
  localparam logic [DATA_W-1:0]      RD_ZERO      = 32'h0000_0000;

endpackage : pic_pkg

// *** src/pic_arb_if.sv ***
`timescale 1ns/1ps

interface pic_arb_if;
  import pic_pkg::*;

  logic [NUM_SRC-1:0]   pending;
  logic [2*NUM_SRC-1:0] level;
  logic                 valid;
  logic [SRC_W-1:0]     win_src;
  pic_level_t           win_level;

  modport ctl (output pending, output level, input valid, input win_src, input win_level);
  modport arb (input pending, input level, output valid, output win_src, output win_level);

endinterface : pic_arb_if

// *** src/pic_arbiter.sv ***
`timescale 1ns/1ps

module pic_arbiter (
  pic_arb_if.arb bus
);
  import pic_pkg::*;

  pic_level_t eff_lvl [NUM_SRC];

  // ---------------------------------------------------------------
  // effective level per source
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_lvl
    pic_level_t prog;
    assign prog = bus.level[i*LVL_W +: LVL_W];
    assign eff_lvl[i] = (FORCED_ALWAYS[i] || (FORCED_IF_EN[i] && prog != LVL_OFF))
                        ? LVL_3 : prog;
  end

  // ---------------------------------------------------------------
  // later hits overwrite: higher level, then higher index wins
  // ---------------------------------------------------------------
  always_comb begin
    bus.valid     = 1'b0;
    bus.win_src   = '0;
    bus.win_level = LVL_OFF;
    for (int l = LVL_1; l <= LVL_3; l++) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (bus.pending[i] && eff_lvl[i] == LVL_W'(l)) begin
          bus.valid     = 1'b1;
          bus.win_src   = SRC_W'(i);
          bus.win_level = LVL_W'(l);
        end
      end
    end
  end

endmodule : pic_arbiter

// *** src/pic_top.sv ***
`timescale 1ns/1ps
// Operation
// - writing one to the global enable bit enables interrupt servicing
// - global enable clears on disable, acknowledge, write zero, reset, traps
// - three priority levels per source, level three highest, one lowest
// - a higher-level pending request always beats any lower-level one
// - within one level a fixed per-source ranking picks the winner
// - watchdog when enabled, oscillator fails, illegal trap forced to level three
// - one-cycle request pulses are caught in sticky pending bits
// - acknowledge clears that source's pending bit until it pulses again
// - writing zero to a pending bit clears it like an acknowledge
// - polarity bit zero triggers on falling pin edge, one on rising
// - select bit six routes pin six or comparator to shared interrupt
// - shared interrupt is edge triggered; changing selection may cause an edge

module pic_top (
  input  wire  logic                          pclk,
  input  wire  logic                          presetn,
  input  wire  logic [pic_pkg::APB_AW-1:0]    paddr,
  input  wire  logic                          psel,
  input  wire  logic                          penable,
  input  wire  logic                          pwrite,
  input  wire  logic [pic_pkg::DATA_W-1:0]    pwdata,
  output logic       [pic_pkg::DATA_W-1:0]    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire  logic [pic_pkg::NUM_PIN-1:0]   port_a_pin_input,
  input  wire  logic                          comparator_out,
  input  wire  logic [pic_pkg::NUM_PER-1:0]   periph_irq_pulse,
  input  wire  logic                          wdt_irq_pulse,
  input  wire  logic                          pri_osc_fail_pulse,
  input  wire  logic                          wdt_osc_fail_pulse,
  input  wire  logic                          illegal_trap_pulse,
  input  wire  logic                          trap_instr_pulse,
  input  wire  logic                          disable_interrupt_instruction,
  input  wire  logic                          core_ack,
  output logic                                core_req,
  output logic       [pic_pkg::SRC_W-1:0]     core_vector,
  output logic       [pic_pkg::LVL_W-1:0]     core_level,
  output logic                                global_interrupt_enable,
  output logic                                irq
);
  import pic_pkg::*;

  // ---------------------------------------------------------------
  // addresses
  // ---------------------------------------------------------------
  localparam logic [APB_AW-1:0] A_PENDING  = {IDX_PENDING, 2'h0};
  localparam logic [APB_AW-1:0] A_LEVEL    = {IDX_LEVEL, 2'h0};
  localparam logic [APB_AW-1:0] A_CTRL     = {IDX_CTRL, 2'h0};
  localparam logic [APB_AW-1:0] A_STATUS   = {IDX_STATUS, 2'h0};
  localparam logic [APB_AW-1:0] A_MASK     = {IDX_MASK, 2'h0};
  localparam logic [APB_AW-1:0] A_EDGE_POL = {IDX_EDGE_POL, 2'h0};
  localparam logic [APB_AW-1:0] A_SRC_SEL  = {IDX_SRC_SEL, 2'h0};

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SRC-1:0]   pending;
    logic [2*NUM_SRC-1:0] level;
    logic                 gie;
    logic [REG_W-1:0]     edge_pol;
    logic                 pin6_comparator_source_select;
    logic [NUM_PIN-1:0]   pin_prev;
    logic                 pin_primed;
    logic [ST_W-1:0]      status;
    logic [ST_W-1:0]      mask;
    logic [DATA_W-1:0]    prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 core_req;
    logic [SRC_W-1:0]     core_vector;
    pic_level_t           core_level;
    logic                 irq;
  } pic_state_t;

  localparam pic_state_t ST_RESET = '{
    pending                       : RST_PENDING,
    level                         : RST_LEVEL,
    gie                           : 1'b0,
    edge_pol                      : RST_EDGE_POL,
    pin6_comparator_source_select : 1'b0,
    pin_prev                      : '0,
    pin_primed                    : 1'b0,
    status                        : RST_ST,
    mask                          : RST_ST,
    prdata                        : RD_ZERO,
    pready                        : 1'b0,
    pslverr                       : 1'b0,
    core_req                      : 1'b0,
    core_vector                   : '0,
    core_level                    : LVL_OFF,
    irq                           : 1'b0
  };

  pic_state_t          st;
  pic_state_t          next_st;

  logic [NUM_PIN-1:0]  pin_now;
  logic [NUM_PIN-1:0]  pin_edge;
  logic [NUM_SRC-1:0]  set_vec;
  logic [NUM_SRC-1:0]  keep_vec;
  logic [NUM_SRC-1:0]  ack_vec;
  logic [NUM_SRC-1:0]  next_pending;
  logic [2*NUM_SRC-1:0] next_level;
  logic                access;
  logic                wr;
  logic                setup;
  logic                ack_taken;
  logic                trap_any;

  pic_arb_if arb_bus ();

  pic_arbiter u_arb (
    .bus (arb_bus)
  );

  // ---------------------------------------------------------------
  // pin edge detection
  // ---------------------------------------------------------------
  always_comb begin
    pin_now             = port_a_pin_input;
    pin_now[PIN_SHARED] = st.pin6_comparator_source_select ? comparator_out
                                                            : port_a_pin_input[PIN_SHARED];
  end

  for (genvar i = 0; i < NUM_PIN; i++) begin : g_pin
    // prev holds the muxed source, so a select change is seen as an edge
    assign pin_edge[i] = st.pin_primed &&
                         (st.edge_pol[i] ? (pin_now[i] && !st.pin_prev[i])
                                         : (!pin_now[i] && st.pin_prev[i]));
  end

  // ---------------------------------------------------------------
  // pending requests
  // ---------------------------------------------------------------
  assign setup     = psel && !penable;
  assign access    = psel && penable && st.pready;
  assign wr        = access && pwrite;
  assign ack_taken = core_ack && st.core_req;
  assign trap_any  = trap_instr_pulse || illegal_trap_pulse || pri_osc_fail_pulse || wdt_osc_fail_pulse;

  always_comb begin
    set_vec                                = '0;
    set_vec[PIN_BASE +: NUM_PIN]           = pin_edge;
    set_vec[PER_BASE +: NUM_PER]           = periph_irq_pulse;
    set_vec[SRC_WDT]                       = wdt_irq_pulse;
    set_vec[SRC_PRI_OSC]                   = pri_osc_fail_pulse;
    set_vec[SRC_WDT_OSC]                   = wdt_osc_fail_pulse;
    set_vec[SRC_ILLEGAL]                   = illegal_trap_pulse;
    keep_vec                               = (wr && paddr == A_PENDING) ? pwdata[NUM_SRC-1:0]
                                                                        : '1;
    ack_vec                                = '0;
    ack_vec[st.core_vector]                = ack_taken;
  end

  // new pulses win over any clear in the same cycle
  assign next_pending   = (st.pending & keep_vec & ~ack_vec) | set_vec;
  // level for the arbiter, kept apart from next_st so no loop forms
  assign next_level      = (wr && paddr == A_LEVEL) ? pwdata : st.level;
  assign arb_bus.pending = next_pending;
  assign arb_bus.level   = next_level;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.pending    = next_pending;
    next_st.pin_prev   = pin_now;
    next_st.pin_primed = 1'b1;

    // register writes at the access edge
    if (wr) begin
      case (paddr)
        A_LEVEL:    next_st.level = pwdata;
        A_CTRL:     next_st.gie   = pwdata[CTRL_GIE_BIT];
        A_MASK:     next_st.mask  = pwdata[ST_W-1:0];
        A_EDGE_POL: next_st.edge_pol = pwdata[REG_W-1:0];
        A_SRC_SEL:  next_st.pin6_comparator_source_select = pwdata[SEL_PIN6_BIT];
        default:    next_st.gie   = st.gie;
      endcase
    end

    // hardware disables win over a software enable
    if (disable_interrupt_instruction || ack_taken || trap_any) begin
      next_st.gie = 1'b0;
    end

    // sticky events, cleared by a read, set wins
    if (access && !pwrite && paddr == A_STATUS) begin
      next_st.status = st.status & ~st.prdata[ST_W-1:0];
    end
    next_st.status[ST_ACK_BIT]  = next_st.status[ST_ACK_BIT] || ack_taken;
    next_st.status[ST_TRAP_BIT] = next_st.status[ST_TRAP_BIT] || trap_any;
    next_st.irq                 = |(next_st.status & next_st.mask);

    // apb: answer prepared in setup, accepted in access
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    next_st.prdata  = RD_ZERO;
    if (setup) begin
      case (paddr)
        A_PENDING:  next_st.prdata[NUM_SRC-1:0] = st.pending;
        A_LEVEL:    next_st.prdata              = st.level;
        A_CTRL:     next_st.prdata[CTRL_GIE_BIT] = st.gie;
        A_STATUS:   next_st.prdata[ST_W-1:0]    = st.status;
        A_MASK:     next_st.prdata[ST_W-1:0]    = st.mask;
        A_EDGE_POL: next_st.prdata[REG_W-1:0]   = st.edge_pol;
        A_SRC_SEL:  next_st.prdata[SEL_PIN6_BIT] = st.pin6_comparator_source_select;
        default:    next_st.pslverr             = 1'b1;
      endcase
    end

    // presentation to the core
    next_st.core_req    = next_st.gie && arb_bus.valid;
    next_st.core_vector = arb_bus.win_src;
    next_st.core_level  = arb_bus.win_level;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata                  = st.prdata;
  assign pready                  = st.pready;
  assign pslverr                 = st.pslverr;
  assign core_req                = st.core_req;
  assign core_vector             = st.core_vector;
  assign core_level              = st.core_level;
  assign global_interrupt_enable = st.gie;
  assign irq                     = st.irq;

endmodule : pic_top

// *** verification/pic_top_chk.sv ***
`timescale 1ns/1ps
module pic_top_chk
  import pic_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              pready,
  input wire logic              illegal_trap_pulse,
  input wire logic              pri_osc_fail_pulse,
  input wire logic              wdt_osc_fail_pulse,
  input wire logic              trap_instr_pulse,
  input wire logic              disable_interrupt_instruction,
  input wire logic              core_ack,
  input wire logic              core_req,
  input wire logic [SRC_W-1:0]  core_vector,
  input wire logic [LVL_W-1:0]  core_level,
  input wire logic              global_interrupt_enable
);
  // ---------------------------------------------------------------
  // core request and global enable checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic clr_ev;
  assign clr_ev = illegal_trap_pulse | trap_instr_pulse | disable_interrupt_instruction | pri_osc_fail_pulse |
                  wdt_osc_fail_pulse;

  sequence s_ack;
    core_req && core_ack;
  endsequence
  sequence s_gie_set;
    psel && penable && pready && pwrite && paddr == {IDX_CTRL, 2'h0} && pwdata[0];
  endsequence

  a_ack_drops_req: assert property (s_ack |=> !core_req)
    else $error("request still shown after acknowledge");
  a_ack_kills_gie: assert property (s_ack |=> !global_interrupt_enable)
    else $error("enable kept after acknowledge");
  a_trap_kills_gie: assert property (clr_ev |=> !global_interrupt_enable)
    else $error("enable kept after trap or disable");
  a_req_needs_gie: assert property (core_req |-> global_interrupt_enable)
    else $error("request shown while disabled");
  a_forced_top_lvl: assert property (core_req && core_vector >= 4'hd |-> core_level == 2'h3)
    else $error("critical source not at top level");
  a_level_in_range: assert property (core_req |-> core_level != 2'h0)
    else $error("request shown with level zero");
  a_gie_write_sets: assert property ((s_gie_set ##0 (!clr_ev && !core_ack)) |=> global_interrupt_enable)
    else $error("enable write had no effect");
  a_req_holds_on: assert property (core_req && !core_ack && !clr_ev && !(psel && penable && pwrite) |=> core_req)
    else $error("request dropped without clear");
endmodule : pic_top_chk

bind pic_top pic_top_chk i_pic_top_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .illegal_trap_pulse(illegal_trap_pulse),
  .pri_osc_fail_pulse(pri_osc_fail_pulse), .wdt_osc_fail_pulse(wdt_osc_fail_pulse),
  .trap_instr_pulse(trap_instr_pulse), .disable_interrupt_instruction(disable_interrupt_instruction),
  .core_ack(core_ack), .core_req(core_req), .core_vector(core_vector), .core_level(core_level),
  .global_interrupt_enable(global_interrupt_enable));

// *** verification/pic_core_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core side: acks a shown request ack_dly plus one cycles after it is shown
// ---------------------------------------------------------------
module pic_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_req,
  input  wire logic [3:0] core_vector,
  input  wire logic [3:0] ack_dly,
  output logic            core_ack,
  output logic      [3:0] acked_vec
);
  logic [3:0] wait_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack  <= 1'b0;
      acked_vec <= 4'h0;
      wait_cnt  <= 4'h0;
    end else begin
      core_ack <= 1'b0;
      if (core_req && !core_ack && wait_cnt == ack_dly) begin
        core_ack  <= 1'b1;
        acked_vec <= core_vector;
        wait_cnt  <= 4'h0;
      end else if (core_req && !core_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else if (!core_req) begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule : pic_core_model

// *** verification/pic_top_tb_top.sv ***
`timescale 1ns/1ps
module pic_top_tb_top;
  import pic_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic              cmp_out, ill, wdt, posc, wosc, trp, dis, core_ack, core_req, gie, irq;
  logic [APB_AW-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [7:0]        port_a;
  logic [3:0]        per, vec, acked_vec, ack_dly;
  logic [1:0]        lvl;
  int                mismatches, tests_run;

  pic_top i_pic_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_pin_input(port_a), .comparator_out(cmp_out), .periph_irq_pulse(per), .wdt_irq_pulse(wdt),
    .pri_osc_fail_pulse(posc), .wdt_osc_fail_pulse(wosc), .illegal_trap_pulse(ill),
    .trap_instr_pulse(trp), .disable_interrupt_instruction(dis), .core_ack(core_ack),
    .core_req(core_req), .core_vector(vec), .core_level(lvl), .global_interrupt_enable(gie), .irq(irq));
  pic_core_model i_pic_core_model (.pclk(pclk), .presetn(presetn), .core_req(core_req),
    .core_vector(vec), .ack_dly(ack_dly), .core_ack(core_ack), .acked_vec(acked_vec));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) mismatches++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc
  // e is {disable, trap instr, wdt osc fail, pri osc fail, wdt, illegal}
  task automatic pulse(input logic [3:0] p, input logic [5:0] e);
    @(posedge pclk);
    per                              <= p;
    {dis, trp, wosc, posc, wdt, ill} <= e;
    @(posedge pclk);
    per                              <= 4'h0;
    {dis, trp, wosc, posc, wdt, ill} <= 6'h00;
  endtask : pulse
  task automatic wait_ack;
    int n;
    n = 0;
    while (core_ack !== 1'b1 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    if (n == 64) mismatches++;
    repeat (2) @(posedge pclk);
  endtask : wait_ack

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rdc("pol reset", IDX_EDGE_POL, 32'h0);
    rdc("sel reset", IDX_SRC_SEL, 32'h0);
    wr(IDX_EDGE_POL, 32'ha5);
    rdc("pol rw", IDX_EDGE_POL, 32'ha5);
    apb(1'b0, 12'h800, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_pins;
    wr(IDX_EDGE_POL, 32'h41);
    @(posedge pclk);
    port_a  <= 8'h01;
    cmp_out <= 1'b1;
    rdc("pin edges", IDX_PENDING, 32'h3);
    wr(IDX_PENDING, 32'h0);
    rdc("write zero", IDX_PENDING, 32'h0);
    wr(IDX_SRC_SEL, 32'h40);
    rdc("sel switch", IDX_PENDING, 32'h40);
    wr(IDX_PENDING, 32'h0);
    cmp_out <= 1'b0;
    rdc("cmp fall", IDX_PENDING, 32'h0);
    cmp_out <= 1'b1;
    rdc("cmp rise", IDX_PENDING, 32'h40);
    wr(IDX_PENDING, 32'h0);
    $display("t_pins done");
  endtask : t_pins
  task automatic t_prio;
    wr(IDX_LEVEL, 32'h0029_0000);
    wr(IDX_MASK, 32'h1);
    pulse(4'h7, 6'h00);
    rdc("sticky", IDX_PENDING, 32'h0700);
    wr(IDX_CTRL, 32'h1);
    wait_ack;
    chk("first", 32'ha, {28'h0, acked_vec});
    chk("ack gie", 32'h0, {31'h0, gie});
    chk("irq up", 32'h1, {31'h0, irq});
    rdc("status", IDX_STATUS, 32'h1);
    @(posedge pclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    wr(IDX_CTRL, 32'h1);
    wait_ack;
    chk("second", 32'h9, {28'h0, acked_vec});
    wr(IDX_CTRL, 32'h1);
    wait_ack;
    chk("third", 32'h8, {28'h0, acked_vec});
    rdc("acked", IDX_PENDING, 32'h0);
    wr(IDX_MASK, 32'h0);
    @(posedge pclk);
    chk("masked", 32'h0, {31'h0, irq});
    $display("t_prio done");
  endtask : t_prio
  task automatic t_trap;
    wr(IDX_LEVEL, 32'h0010_0000);
    ack_dly <= 4'h6;
    wr(IDX_CTRL, 32'h1);
    pulse(4'h4, 6'h01);
    repeat (2) @(posedge pclk);
    chk("trap gie", 32'h0, {31'h0, gie});
    wr(IDX_CTRL, 32'h1);
    @(posedge pclk);
    chk("trap vec", 32'hf, {28'h0, vec});
    chk("trap lvl", 32'h3, {30'h0, lvl});
    wait_ack;
    wr(IDX_CTRL, 32'h1);
    wait_ack;
    chk("after trap", 32'ha, {28'h0, acked_vec});
    wr(IDX_CTRL, 32'h1);
    wr(IDX_CTRL, 32'h0);
    rdc("gie off", IDX_CTRL, 32'h0);
    $display("t_trap done");
  endtask : t_trap
  task automatic t_crit;
    wr(IDX_CTRL, 32'h1);
    pulse(4'h0, 6'h20);
    @(posedge pclk);
    chk("dis gie", 32'h0, {31'h0, gie});
    wr(IDX_CTRL, 32'h1);
    pulse(4'h0, 6'h10);
    @(posedge pclk);
    chk("trap instr gie", 32'h0, {31'h0, gie});
    wr(IDX_LEVEL, 32'h0180_0000);
    pulse(4'h8, 6'h0a);
    wr(IDX_CTRL, 32'h1);
    @(posedge pclk);
    chk("wosc vec", 32'he, {28'h0, vec});
    wait_ack;
    wr(IDX_CTRL, 32'h1);
    @(posedge pclk);
    chk("wdt vec", 32'hc, {28'h0, vec});
    chk("wdt lvl", 32'h3, {30'h0, lvl});
    wait_ack;
    wr(IDX_CTRL, 32'h1);
    wait_ack;
    chk("lvl two", 32'hb, {28'h0, acked_vec});
    wr(IDX_CTRL, 32'h1);
    pulse(4'h0, 6'h04);
    @(posedge pclk);
    chk("posc gie", 32'h0, {31'h0, gie});
    wr(IDX_CTRL, 32'h1);
    wait_ack;
    chk("posc vec", 32'hd, {28'h0, acked_vec});
    rdc("trap status", IDX_STATUS, 32'h3);
    $display("t_crit done");
  endtask : t_crit

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {presetn, psel, penable, pwrite, cmp_out, ill} = 6'h0;
    {wdt, posc, wosc, trp, dis} = 5'h0;
    paddr = 14'h0;
    pwdata = 32'h0;
    per = 4'h0;
    port_a = 8'h02;
    ack_dly = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_pins;
    t_prio;
    t_trap;
    t_crit;
    wrap_up;
  end

  initial begin
    #50000;
    mismatches++;
    wrap_up;
  end
endmodule : pic_top_tb_top
